// file: common/hri_defs.svh
`ifndef HRI_DEFS_SVH
`define HRI_DEFS_SVH

// Register byte offsets
`define ADR_HOST_WORD 4'h0
`define ADR_REPLY 4'h4
`define ADR_STATUS 4'h8

// Interpreter result codes
`define IST_OK 8'h80
`define IST_BAD_OPCODE 8'h81
`define IST_BAD_PARAMS 8'h82
`define IST_NOT_READY 8'h83
`define IST_OVERFLOW 8'h84
`define IST_READY 8'h85

// Command opcodes
`define OP_NOP 8'h00
`define OP_STAT 8'h01
`define OP_ROM_REV 8'h02
`define OP_GPIO_WRITE 8'h03
`define OP_PLL_SETUP 8'h04
`define OP_MEM_READ 8'h05
`define OP_SPDIF_QUERY 8'h06
`define OP_TIME_QUERY 8'h07
`define OP_FN_MPEG 8'h10
`define OP_FN_PCM 8'h11
`define OP_FN_NOISE 8'h12

// Parameter word counts
`define PLEN_NONE 8'h00
`define PLEN_GPIO 8'h04
`define PLEN_PLL 8'h01
`define PLEN_MEM 8'h03
`define PLEN_FUNC 8'h08

// Reply word counts
`define RLEN_NONE 8'h00
`define RLEN_ROM 8'h04
`define RLEN_GPIO 8'h02
`define RLEN_PLL 8'h01
`define RLEN_SPDIF 8'h04
`define RLEN_TIME 8'h08
`define RLEN_MPEG 8'h0C
`define RLEN_EIGHT 8'h08

// Memory read limits, word indices and function IDs
`define MEM_MAX_WORDS 8'h3F
`define MEM_CNT_PARAM 3'h2
`define LAST_BYTE 2'h3
`define FN_ID_MPEG 4'h7
`define FN_ID_NOISE 4'h3
`define VERSION_WORD 8'h06

`endif

// file: common/hri_pkg.sv
package hri_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b0_0001,
        ST_PARAM = 5'b0_0010,
        ST_RCOUNT = 5'b0_0100,
        ST_RDATA = 5'b0_1000,
        ST_ISTAT = 5'b1_0000
    } phase_e;

    typedef enum logic [1:0] {
        FN_NONE = 2'h0,
        FN_MPEG = 2'h1,
        FN_PCM = 2'h2,
        FN_NOISE = 2'h3
    } func_e;
endpackage : hri_pkg

// file: design/host_reply_interpreter.sv
`timescale 1ns/10ps
`default_nettype none
`include "hri_defs.svh"

module host_reply_interpreter
    import hri_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [3:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic EXEC_BUSY,
    output logic EXEC_START,
    output logic [7:0] EXEC_OPCODE,
    output logic [63:0] EXEC_PARAMS,
    input wire logic [3:0] RUN_STATUS,
    input wire logic DECODER_RESET,
    input wire logic [2:0] DECODE_ERROR_CODE,
    input wire logic [15:0] DIFF_TIME,
    input wire logic ALGORITHM_ID,
    input wire logic [1:0] FRAME_TIER_CODE,
    input wire logic CRC_ABSENT_FLAG,
    input wire logic [3:0] BITRATE_INDEX,
    input wire logic [1:0] SAMPLING_RATE_CODE,
    input wire logic PADDING_FLAG,
    input wire logic PRIVATE_FLAG,
    input wire logic [1:0] CHANNEL_MODE_CODE,
    input wire logic [1:0] JOINT_EXTENSION,
    input wire logic COPYRIGHT_FLAG,
    input wire logic ORIGINAL_FLAG,
    input wire logic [1:0] TONE_CURVE_CODE,
    input wire logic [63:0] SURROUND_WORDS,
    input wire logic [7:0] PCM_MATRIX_VERSION,
    input wire logic [7:0] NOISE_VERSION,
    input wire logic [31:0] ROM_VERSION,
    input wire logic [5:0] GPIO_CONTROL_REG,
    input wire logic [5:0] GPIO_VALUE,
    input wire logic AUDIO_PLL_LOCK,
    input wire logic CORE_PLL_LOCK,
    output logic [15:0] MEMORY_READ_CMD_ADDR,
    input wire logic [31:0] MEMORY_READ_CMD_DATA,
    input wire logic [1:0] INPUT_RATE_CODE,
    input wire logic [7:0] CATEGORY_CODE,
    input wire logic EMPHASIS_FLAG,
    input wire logic SPDIF_COPYRIGHT,
    input wire logic NON_PCM_FLAG,
    input wire logic [6:0] RECEIVER_FLAGS,
    input wire logic [31:0] PRESENTATION_TIME,
    input wire logic [31:0] SYSTEM_TIME
);

    phase_e state_reg;
    func_e func_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [7:0] reply_reg;
    logic reply_valid_reg;
    logic [7:0] op_reg;
    logic [7:0] cnt_reg;
    logic [7:0] plen_reg;
    logic [7:0] rlen_reg;
    logic [7:0] idx_reg;
    logic [63:0] params_reg;
    logic ovf_reg;
    logic exec_reg;
    logic [15:0] addr_reg;
    logic bus_req;
    logic bus_fire;
    logic wr_word;
    logic rd_pop;
    logic [7:0] in_byte;
    logic [7:0] cat_rev;
    logic [7:0] next_idx;
    logic [2:0] pidx;

    // Byte k of a 32-bit word, most significant first
    function automatic logic [7:0] msb_byte(input logic [31:0] w,
                                            input logic [1:0] k);
        logic [7:0] b;
        b = 8'h00;
        case (k)
            2'h0: b = w[31:24];
            2'h1: b = w[23:16];
            2'h2: b = w[15:8];
            default: b = w[7:0];
        endcase
        return b;
    endfunction : msb_byte

    // Parameter words each opcode expects
    function automatic logic [7:0] param_len(input logic [7:0] op);
        logic [7:0] n;
        n = `PLEN_NONE;
        if (op == `OP_GPIO_WRITE) begin
            n = `PLEN_GPIO;
        end else if (op == `OP_PLL_SETUP) begin
            n = `PLEN_PLL;
        end else if (op == `OP_MEM_READ) begin
            n = `PLEN_MEM;
        end else if (op == `OP_FN_MPEG || op == `OP_FN_PCM ||
                     op == `OP_FN_NOISE) begin
            n = `PLEN_FUNC;
        end
        return n;
    endfunction : param_len

    function automatic logic known_op(input logic [7:0] op);
        return (op <= `OP_TIME_QUERY) ||
               (op >= `OP_FN_MPEG && op <= `OP_FN_NOISE);
    endfunction : known_op

    // Reply words for an opcode; memory read is sized elsewhere
    function automatic logic [7:0] reply_len(input logic [7:0] op,
                                             input func_e fn);
        logic [7:0] n;
        n = `RLEN_NONE;
        if (op == `OP_ROM_REV) begin
            n = `RLEN_ROM;
        end else if (op == `OP_GPIO_WRITE) begin
            n = `RLEN_GPIO;
        end else if (op == `OP_PLL_SETUP) begin
            n = `RLEN_PLL;
        end else if (op == `OP_SPDIF_QUERY) begin
            n = `RLEN_SPDIF;
        end else if (op == `OP_TIME_QUERY) begin
            n = `RLEN_TIME;
        end else if (op == `OP_STAT && fn == FN_MPEG) begin
            n = `RLEN_MPEG;
        end else if (op == `OP_STAT && fn != FN_NONE) begin
            n = `RLEN_EIGHT;
        end
        return n;
    endfunction : reply_len

    // Reply byte idx of the running command
    function automatic logic [7:0] reply_byte(input logic [7:0] op,
                                              input logic [7:0] idx);
        logic [7:0] b;
        b = 8'h00;
        if (op == `OP_ROM_REV) begin
            b = msb_byte(ROM_VERSION, idx[1:0]);
        end else if (op == `OP_GPIO_WRITE) begin
            b = (idx == 8'h00) ? {2'b00, GPIO_CONTROL_REG}
                               : {2'b00, GPIO_VALUE};
        end else if (op == `OP_PLL_SETUP) begin
            b = {6'h00, AUDIO_PLL_LOCK, CORE_PLL_LOCK};
        end else if (op == `OP_MEM_READ) begin
            b = msb_byte(MEMORY_READ_CMD_DATA, idx[1:0]);
        end else if (op == `OP_SPDIF_QUERY) begin
            case (idx[1:0])
                2'h0: b = {INPUT_RATE_CODE, 3'b000,
                           EMPHASIS_FLAG & ~NON_PCM_FLAG,
                           SPDIF_COPYRIGHT, NON_PCM_FLAG};
                2'h1: b = cat_rev;
                2'h2: b = {1'b0, RECEIVER_FLAGS};
                default: b = 8'h00;
            endcase
        end else if (op == `OP_TIME_QUERY) begin
            b = idx[2] ? msb_byte(SYSTEM_TIME, idx[1:0])
                       : msb_byte(PRESENTATION_TIME, idx[1:0]);
        end else if (op == `OP_STAT && func_reg == FN_MPEG) begin
            case (idx)
                8'h00: b = {RUN_STATUS, `FN_ID_MPEG};
                8'h01: b = {DECODER_RESET, 4'h0,
                            DECODE_ERROR_CODE};
                8'h04: b = DIFF_TIME[15:8];
                8'h05: b = DIFF_TIME[7:0];
                8'h06: b = {4'h0, ALGORITHM_ID, FRAME_TIER_CODE,
                            CRC_ABSENT_FLAG};
                8'h07: b = {BITRATE_INDEX, SAMPLING_RATE_CODE,
                            PADDING_FLAG, PRIVATE_FLAG};
                8'h08: b = {CHANNEL_MODE_CODE, JOINT_EXTENSION,
                            COPYRIGHT_FLAG, ORIGINAL_FLAG,
                            TONE_CURVE_CODE};
                default: b = 8'h00;
            endcase
        end else if (op == `OP_STAT && func_reg == FN_PCM) begin
            if (idx == `VERSION_WORD) begin
                b = PCM_MATRIX_VERSION;
            end else begin
                b = SURROUND_WORDS[{idx[2:0], 3'b000} +: 8];
            end
        end else if (op == `OP_STAT && func_reg == FN_NOISE) begin
            case (idx)
                8'h00: b = {RUN_STATUS, `FN_ID_NOISE};
                8'h01: b = {DECODER_RESET, 7'h00};
                `VERSION_WORD: b = NOISE_VERSION;
                default: b = 8'h00;
            endcase
        end
        return b;
    endfunction : reply_byte

    // Register read data
    function automatic logic [31:0] read_word(input logic [3:0] adr);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (adr == `ADR_REPLY) begin
            w = {24'h00_0000, reply_valid_reg ? reply_reg : 8'h00};
        end else if (adr == `ADR_STATUS) begin
            w = {16'h0000, op_reg, 1'b0, func_reg, state_reg};
        end
        return w;
    endfunction : read_word

    // Category code arrives in channel-status order
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_cat
            assign cat_rev[gi] = CATEGORY_CODE[7 - gi];
        end
    endgenerate

    // Bus strobes; effects land on the edge the master sees ack
    assign bus_req = CYC_I & STB_I;
    assign bus_fire = bus_req & ack_reg & CE;
    assign wr_word = bus_fire & WE_I & SEL_I[0] &
                     (ADR_I == `ADR_HOST_WORD);
    assign rd_pop = bus_fire & ~WE_I & (ADR_I == `ADR_REPLY) &
                    reply_valid_reg;
    assign in_byte = DAT_I[7:0];
    assign next_idx = idx_reg + 8'h01;
    assign pidx = 3'(plen_reg - cnt_reg);
    assign ACK_O = ack_reg & bus_req & CE; // Frozen ack would lose the write
    assign DAT_O = dat_reg;
    assign EXEC_START = exec_reg;
    assign EXEC_OPCODE = op_reg;
    assign EXEC_PARAMS = params_reg;
    assign MEMORY_READ_CMD_ADDR = addr_reg;

    // Wishbone slave: one wait state, data latched with the ack
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else if (CE) begin
            ack_reg <= bus_req & ~ack_reg;
            if (bus_req & ~ack_reg) begin
                dat_reg <= read_word(ADR_I);
            end
        end
    end

    // Command interpreter and reply sequencer
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_reg <= ST_IDLE;
            func_reg <= FN_NONE;
            reply_reg <= 8'h00;
            reply_valid_reg <= 1'b0;
            op_reg <= `OP_NOP;
            cnt_reg <= 8'h00;
            plen_reg <= 8'h00;
            rlen_reg <= 8'h00;
            idx_reg <= 8'h00;
            params_reg <= 64'h0000_0000_0000_0000;
            ovf_reg <= 1'b0;
            exec_reg <= 1'b0;
        end else if (CE) begin
            exec_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (wr_word) begin
                        ovf_reg <= 1'b0;
                        reply_valid_reg <= 1'b1;
                        idx_reg <= 8'h00;
                        if (EXEC_BUSY) begin
                            reply_reg <= `IST_NOT_READY;
                            state_reg <= ST_ISTAT;
                        end else if (!known_op(in_byte)) begin
                            reply_reg <= `IST_BAD_OPCODE;
                            state_reg <= ST_ISTAT;
                        end else if (param_len(in_byte) != 8'h00) begin
                            op_reg <= in_byte;
                            plen_reg <= param_len(in_byte);
                            cnt_reg <= param_len(in_byte);
                            reply_reg <= param_len(in_byte);
                            state_reg <= ST_PARAM;
                        end else begin
                            op_reg <= in_byte;
                            exec_reg <= 1'b1;
                            rlen_reg <= reply_len(in_byte, func_reg);
                            if (reply_len(in_byte, func_reg) != 8'h00) begin
                                reply_reg <= reply_len(in_byte, func_reg);
                                state_reg <= ST_RCOUNT;
                            end else begin
                                reply_reg <= (in_byte == `OP_NOP) ?
                                             `IST_READY : `IST_OK;
                                state_reg <= ST_ISTAT;
                            end
                        end
                    end
                end
                ST_PARAM: begin
                    if (rd_pop) begin
                        reply_valid_reg <= 1'b0;
                    end else if (wr_word && reply_valid_reg) begin
                        ovf_reg <= 1'b1; // Word dropped, host ran ahead
                    end else if (wr_word) begin
                        params_reg[{pidx, 3'b000} +: 8] <= in_byte;
                        cnt_reg <= cnt_reg - 8'h01;
                        reply_valid_reg <= 1'b1;
                        if (cnt_reg != 8'h01) begin
                            reply_reg <= cnt_reg - 8'h01;
                        end else if (op_reg == `OP_MEM_READ &&
                                     (in_byte == 8'h00 ||
                                      in_byte > `MEM_MAX_WORDS)) begin
                            reply_reg <= `IST_BAD_PARAMS;
                            state_reg <= ST_ISTAT;
                        end else if (ovf_reg) begin
                            reply_reg <= `IST_OVERFLOW;
                            state_reg <= ST_ISTAT;
                        end else begin
                            exec_reg <= 1'b1;
                            if (op_reg == `OP_FN_MPEG) begin
                                func_reg <= FN_MPEG;
                            end else if (op_reg == `OP_FN_PCM) begin
                                func_reg <= FN_PCM;
                            end else if (op_reg == `OP_FN_NOISE) begin
                                func_reg <= FN_NOISE;
                            end
                            if (op_reg == `OP_MEM_READ) begin
                                rlen_reg <= {in_byte[5:0], 2'b00};
                                reply_reg <= {in_byte[5:0], 2'b00};
                                state_reg <= ST_RCOUNT;
                            end else if (reply_len(op_reg, func_reg)
                                         != 8'h00) begin
                                rlen_reg <= reply_len(op_reg, func_reg);
                                reply_reg <= reply_len(op_reg, func_reg);
                                state_reg <= ST_RCOUNT;
                            end else begin
                                reply_reg <= `IST_OK;
                                state_reg <= ST_ISTAT;
                            end
                        end
                    end
                end
                ST_RCOUNT: begin
                    if (wr_word) begin
                        ovf_reg <= 1'b1;
                    end
                    if (rd_pop) begin
                        reply_reg <= reply_byte(op_reg, 8'h00);
                        idx_reg <= 8'h00;
                        state_reg <= ST_RDATA;
                    end
                end
                ST_RDATA: begin
                    if (wr_word) begin
                        ovf_reg <= 1'b1;
                    end
                    if (rd_pop) begin
                        idx_reg <= next_idx;
                        if (next_idx == rlen_reg) begin
                            reply_reg <= (ovf_reg || wr_word) ?
                                         `IST_OVERFLOW : `IST_OK;
                            state_reg <= ST_ISTAT;
                        end else begin
                            reply_reg <= reply_byte(op_reg, next_idx);
                        end
                    end
                end
                ST_ISTAT: begin
                    if (rd_pop) begin
                        reply_valid_reg <= 1'b0;
                        state_reg <= ST_IDLE;
                    end else if (wr_word) begin
                        reply_reg <= `IST_OVERFLOW;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    reply_valid_reg <= 1'b0;
                end
            endcase
        end
    end

    // Memory word address; the next word is fetched on the pop that loads the
    // last byte, so memory gets at least two cycles to answer
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            addr_reg <= 16'h0000;
        end else if (CE) begin
            if (state_reg == ST_PARAM && wr_word && !reply_valid_reg &&
                pidx == `MEM_CNT_PARAM) begin
                addr_reg <= params_reg[15:0];
            end else if (state_reg == ST_RDATA && rd_pop &&
                         op_reg == `OP_MEM_READ &&
                         next_idx[1:0] == `LAST_BYTE) begin
                addr_reg <= addr_reg + 16'h0001;
            end
        end
    end

endmodule : host_reply_interpreter
`default_nettype wire

// file: dv/host_reply_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module host_reply_monitor (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [3:0] ADR_I,
    input wire logic [31:0] DAT_O,
    input wire logic ACK_O,
    input wire logic EXEC_BUSY,
    input wire logic EXEC_START
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    // Bus side: one wait state, one-cycle ack, data held between requests
    a_ack_one_wait: assert property ($rose(CYC_I && STB_I) |-> !ACK_O ##1 ACK_O)
        else $error("ack not after one wait state");
    a_ack_single: assert property (ACK_O |=> !ACK_O)
        else $error("ack longer than one cycle");
    a_ack_gated: assert property (!(CYC_I && STB_I) |-> !ACK_O)
        else $error("ack without request");
    a_data_held: assert property (!(CYC_I && STB_I) |=> $stable(DAT_O))
        else $error("read data moved between requests");
    a_unmapped_zero: assert property (ACK_O && !WE_I
        && !(ADR_I inside {4'h0, 4'h4, 4'h8}) |-> DAT_O == 32'h0000_0000)
        else $error("unmapped read not zero");
    // Hand-over only after an accepted command word, never while busy
    a_start_pulse: assert property (EXEC_START |=> !EXEC_START)
        else $error("start longer than one cycle");
    a_start_cause: assert property (EXEC_START |->
        $past(ACK_O && WE_I && ADR_I == 4'h0))
        else $error("start without command write");
    a_start_idle: assert property (EXEC_START |-> !$past(EXEC_BUSY))
        else $error("start while executor busy");
endmodule : host_reply_monitor

bind host_reply_interpreter host_reply_monitor host_reply_monitor_i (
    .CLK(CLK), .RST_N(RST_N), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .EXEC_BUSY(EXEC_BUSY),
    .EXEC_START(EXEC_START));
`default_nettype wire

// file: dv/host_exec_partner.sv
`timescale 1ns/10ps
`default_nettype none
module host_exec_partner (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic start,
    input wire logic [15:0] memory_read_cmd_addr,
    output logic busy,
    output logic [31:0] memory_read_cmd_data
);
    logic [5:0] cnt_reg;
    // Busy after each hand-over; slow mode lets a second command collide
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= 6'h00;
        end else if (start) begin
            cnt_reg <= slow ? 6'h28 : 6'h02;
        end else if (cnt_reg != 6'h00) begin
            cnt_reg <= cnt_reg - 6'h01;
        end
    end
    assign busy = (cnt_reg != 6'h00);
    // Memory word one cycle after its address, pattern tied to the address
    always_ff @(posedge clk) begin
        memory_read_cmd_data <= {memory_read_cmd_addr, ~memory_read_cmd_addr};
    end
endmodule : host_exec_partner
`default_nettype wire

// file: dv/host_reply_interpreter_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "hri_defs.svh"
module host_reply_interpreter_tb_top;
    logic CLK, RST_N, CE, CYC_I, STB_I, WE_I, DECODER_RESET, ALGORITHM_ID;
    logic CRC_ABSENT_FLAG, PADDING_FLAG, PRIVATE_FLAG, COPYRIGHT_FLAG;
    logic ORIGINAL_FLAG, AUDIO_PLL_LOCK, CORE_PLL_LOCK, EMPHASIS_FLAG;
    logic SPDIF_COPYRIGHT, NON_PCM_FLAG, ACK_O, EXEC_BUSY, EXEC_START, slow;
    logic [1:0] FRAME_TIER_CODE, SAMPLING_RATE_CODE, CHANNEL_MODE_CODE, pad;
    logic [1:0] JOINT_EXTENSION, TONE_CURVE_CODE, INPUT_RATE_CODE;
    logic [2:0] DECODE_ERROR_CODE;
    logic [3:0] ADR_I, SEL_I, RUN_STATUS, BITRATE_INDEX;
    logic [5:0] GPIO_CONTROL_REG, GPIO_VALUE;
    logic [6:0] RECEIVER_FLAGS;
    logic [7:0] EXEC_OPCODE, PCM_MATRIX_VERSION, NOISE_VERSION, CATEGORY_CODE;
    logic [15:0] DIFF_TIME, MEMORY_READ_CMD_ADDR;
    logic [31:0] DAT_I, DAT_O, ROM_VERSION, MEMORY_READ_CMD_DATA, PRESENTATION_TIME;
    logic [31:0] SYSTEM_TIME;
    logic [63:0] EXEC_PARAMS, SURROUND_WORDS;
    logic [7:0] prm[8];
    logic [7:0] rep[$];
    int n_fail, n_compared, cyc;

    host_reply_interpreter host_reply_interpreter_i (.*);
    host_exec_partner host_exec_partner_i (.clk(CLK), .rst_n(RST_N),
        .slow(slow), .start(EXEC_START), .memory_read_cmd_addr(MEMORY_READ_CMD_ADDR),
        .busy(EXEC_BUSY), .memory_read_cmd_data(MEMORY_READ_CMD_DATA));

    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    // Hang guard, well above the under one thousand cycles the run needs
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string nm, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask : check

    // New status values on every input, settled before use
    task automatic rnd();
        {RUN_STATUS, DECODER_RESET, DECODE_ERROR_CODE, DIFF_TIME, ALGORITHM_ID,
         FRAME_TIER_CODE, CRC_ABSENT_FLAG, BITRATE_INDEX, SAMPLING_RATE_CODE,
         PADDING_FLAG, PRIVATE_FLAG, CHANNEL_MODE_CODE, JOINT_EXTENSION,
         COPYRIGHT_FLAG, ORIGINAL_FLAG, TONE_CURVE_CODE, ROM_VERSION,
         PRESENTATION_TIME, SYSTEM_TIME, SURROUND_WORDS, PCM_MATRIX_VERSION,
         NOISE_VERSION, GPIO_CONTROL_REG, GPIO_VALUE, AUDIO_PLL_LOCK,
         CORE_PLL_LOCK, INPUT_RATE_CODE, CATEGORY_CODE, EMPHASIS_FLAG,
         SPDIF_COPYRIGHT, NON_PCM_FLAG, RECEIVER_FLAGS, pad} <= {$urandom,
         $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
        @(posedge CLK);
    endtask : rnd

    // Classic single cycle; request held until ack is sampled high
    task automatic wb(input logic we, input logic [3:0] a,
                      input logic [7:0] d, output logic [31:0] q);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I <= we;
        ADR_I <= a;
        DAT_I <= {24'h00_0000, d};
        do @(posedge CLK); while (ACK_O !== 1'b1);
        q = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        @(posedge CLK);
    endtask : wb

    task automatic rd(input logic [7:0] e);
        logic [31:0] q;
        wb(1'b0, `ADR_REPLY, 8'h00, q);
        check("reply", q, {24'h00_0000, e});
    endtask : rd

    // Command, parameters with progress words, reply words, final result
    task automatic run(input logic [7:0] op, input int np,
                       input logic [7:0] res, input logic ovf);
        logic [31:0] q;
        wb(1'b1, `ADR_HOST_WORD, op, q);
        if (ovf) wb(1'b1, `ADR_HOST_WORD, 8'h00, q);
        if (np > 0) rd(8'(np));
        for (int k = 0; k < np; k++) begin
            wb(1'b1, `ADR_HOST_WORD, prm[k], q);
            if (np - 1 - k > 0) rd(8'(np - 1 - k));
        end
        if (rep.size() > 0) rd(8'(rep.size()));
        foreach (rep[i]) rd(rep[i]);
        rd(res);
        rep.delete();
        $display("command %h done", op);
    endtask : run

    initial begin
        logic [31:0] q;
        logic [63:0] t;
        logic [7:0] crev;
        q = $urandom(54892);
        {RST_N, CYC_I, STB_I, WE_I, ADR_I, DAT_I, slow} <= '0;
        CE <= 1'b1;
        SEL_I <= 4'hF;
        rnd();
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        wb(1'b0, 4'hC, 8'h00, q);
        check("unmapped", q, 32'h0000_0000);
        rd(8'h00);
        rep = '{ROM_VERSION[31:24], ROM_VERSION[23:16], ROM_VERSION[15:8],
                ROM_VERSION[7:0]};
        run(`OP_ROM_REV, 0, `IST_OK, 1'b0);
        check("opcode", EXEC_OPCODE, 32'h0000_0002);
        prm[0] = 8'($urandom);
        rep = '{{6'h00, AUDIO_PLL_LOCK, CORE_PLL_LOCK}};
        run(`OP_PLL_SETUP, 1, `IST_OK, 1'b0);
        foreach (prm[k]) prm[k] = 8'($urandom);
        rep = '{{2'h0, GPIO_CONTROL_REG}, {2'h0, GPIO_VALUE}};
        run(`OP_GPIO_WRITE, 4, `IST_OK, 1'b0);
        check("params", EXEC_PARAMS[31:0], {prm[3], prm[2], prm[1], prm[0]});
        t = {PRESENTATION_TIME, SYSTEM_TIME};
        for (int k = 7; k >= 0; k--) rep.push_back(t[8*k+:8]);
        run(`OP_TIME_QUERY, 0, `IST_OK, 1'b0);
        repeat (4) begin
            rnd();
            crev = {<<{CATEGORY_CODE}};
            rep = '{{INPUT_RATE_CODE, 3'h0, EMPHASIS_FLAG & ~NON_PCM_FLAG,
                SPDIF_COPYRIGHT, NON_PCM_FLAG}, crev,
                {1'b0, RECEIVER_FLAGS}, 8'h00};
            run(`OP_SPDIF_QUERY, 0, `IST_OK, 1'b0);
        end
        prm[0:2] = '{8'h12, 8'h12, 8'h02};
        for (int a = 0; a < 2; a++) begin
            t[31:0] = {16'h1212 + 16'(a), ~(16'h1212 + 16'(a))};
            for (int k = 3; k >= 0; k--) rep.push_back(t[8*k+:8]);
        end
        run(`OP_MEM_READ, 3, `IST_OK, 1'b0);
        prm[2] = 8'h00;
        run(`OP_MEM_READ, 3, `IST_BAD_PARAMS, 1'b0);
        run(`OP_FN_MPEG, 8, `IST_OK, 1'b0);
        wb(1'b0, `ADR_STATUS, 8'h00, q);
        check("status", q, 32'h0000_1021);
        for (int k = 0; k < 6; k++) begin
            {DECODE_ERROR_CODE, FRAME_TIER_CODE, TONE_CURVE_CODE} <= {3'(k),
                2'(k), 2'(k)};
            {SAMPLING_RATE_CODE, CHANNEL_MODE_CODE} <= {2'(k % 3), 2'(k)};
            @(posedge CLK);
            rep = '{{RUN_STATUS, 4'h7}, {DECODER_RESET, 4'h0,
                DECODE_ERROR_CODE}, 8'h00, 8'h00, DIFF_TIME[15:8],
                DIFF_TIME[7:0], {4'h0, ALGORITHM_ID, FRAME_TIER_CODE,
                CRC_ABSENT_FLAG}, {BITRATE_INDEX, SAMPLING_RATE_CODE,
                PADDING_FLAG, PRIVATE_FLAG}, {CHANNEL_MODE_CODE,
                JOINT_EXTENSION, COPYRIGHT_FLAG, ORIGINAL_FLAG,
                TONE_CURVE_CODE}, 8'h00, 8'h00, 8'h00};
            run(`OP_STAT, 0, `IST_OK, 1'b0);
        end
        run(`OP_FN_NOISE, 8, `IST_OK, 1'b0);
        rep = '{{RUN_STATUS, 4'h3}, {DECODER_RESET, 7'h00}, 8'h00, 8'h00,
                8'h00, 8'h00, NOISE_VERSION, 8'h00};
        run(`OP_STAT, 0, `IST_OK, 1'b0);
        run(`OP_FN_PCM, 8, `IST_OK, 1'b0);
        for (int k = 0; k < 8; k++)
            rep.push_back(k == 6 ? PCM_MATRIX_VERSION : SURROUND_WORDS[8*k+:8]);
        run(`OP_STAT, 0, `IST_OK, 1'b0);
        slow <= 1'b1;
        rep = '{ROM_VERSION[31:24], ROM_VERSION[23:16], ROM_VERSION[15:8],
                ROM_VERSION[7:0]};
        run(`OP_ROM_REV, 0, `IST_OK, 1'b0);
        run(`OP_ROM_REV, 0, `IST_NOT_READY, 1'b0);
        slow <= 1'b0;
        while (EXEC_BUSY !== 1'b0) @(posedge CLK);
        run(`OP_NOP, 0, `IST_READY, 1'b0);
        run(8'h3F, 0, `IST_BAD_OPCODE, 1'b0);
        rep = '{ROM_VERSION[31:24], ROM_VERSION[23:16], ROM_VERSION[15:8],
                ROM_VERSION[7:0]};
        run(`OP_ROM_REV, 0, `IST_OVERFLOW, 1'b1);
        give_verdict();
    end
endmodule : host_reply_interpreter_tb_top
`default_nettype wire
